// [rtl/i2cbl_pkg.sv]
package i2cbl_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int MST_SCL_HZ = 375_000;
	localparam int STD_SCL_HZ = 100_000;
	localparam int FAST_SCL_HZ = 400_000;
	// Cycles per bus bit; quarter and half points are derived by shifts.
	localparam logic [6:0] MST_BIT_CYC = 7'(CLK_HZ / MST_SCL_HZ);
	localparam logic [7:0] HST_STD_BIT = 8'(CLK_HZ / STD_SCL_HZ);
	localparam logic [7:0] HST_FAST_BIT = 8'(CLK_HZ / FAST_SCL_HZ);
	localparam logic [5:0] SLV_BASE = 6'h1A;
	localparam logic [5:0] MST_BASE = 6'h28;
	localparam logic [7:0] GEN_CALL = 8'h00;
	localparam logic [7:0] EE_SUB_HI = 8'h00;
	localparam logic [7:0] EE_SUB_LO = 8'h00;
	localparam logic [7:0] STATUS_SUB = 8'h00;
	localparam logic [7:0] BIQUAD_LO = 8'h10;
	localparam logic [7:0] BIQUAD_HI = 8'h1F;
	localparam logic [7:0] PROG_SUB = 8'h20;
	localparam logic [2:0] BIQUAD_WORDS = 3'h5;
	localparam logic [2:0] CTRL_WORDS = 3'h1;
	localparam int MAX_BYTES = 20;
	localparam logic [31:0] MASK_STATUS = 32'h0000_00FF;
	localparam logic [31:0] MASK_COEF = 32'h0FFF_FFFF;
	localparam logic [31:0] MASK_FULL = 32'hFFFF_FFFF;
	localparam logic [2:0] TGT_PROG = 3'h0;
	localparam logic [2:0] TGT_MAX = 3'h4;
	localparam logic [1:0] RETRY_LAST = 2'h2;
	localparam logic [1:0] CKSUM_LAST = 2'h2;

	typedef enum logic {MODE_BOOT, MODE_SLAVE} i2cbl_mode_t;

	function automatic logic is_biquad(input logic [7:0] sub);
		return (sub >= BIQUAD_LO) && (sub <= BIQUAD_HI);
	endfunction

	function automatic logic [2:0] sub_words(input logic [7:0] sub);
		return is_biquad(sub) ? BIQUAD_WORDS : CTRL_WORDS;
	endfunction

	function automatic logic [31:0] sub_mask(input logic [7:0] sub);
		if (sub == STATUS_SUB) return MASK_STATUS;
		if (is_biquad(sub)) return MASK_COEF;
		return MASK_FULL;
	endfunction
endpackage

// [rtl/i2cbl_if.sv]
`timescale 1ns/1ps
interface i2cbl_if;
	logic scl;
	logic sda;
	logic dev_scl_oe;
	logic dev_scl_out;
	logic dev_sda_oe;
	logic dev_sda_out;
	logic host_scl_oe;
	logic host_scl_out;
	logic host_sda_oe;
	logic host_sda_out;
	// Tied off by the bench; no serial memory model drives them.
	logic ext_scl_oe;
	logic ext_sda_oe;

	// Open-drain wires: any enabled low driver pulls the line low.
	assign scl = ~((dev_scl_oe & ~dev_scl_out) | (host_scl_oe & ~host_scl_out) | ext_scl_oe);
	assign sda = ~((dev_sda_oe & ~dev_sda_out) | (host_sda_oe & ~host_sda_out) | ext_sda_oe);

	modport dev (input scl, input sda, output dev_scl_oe, output dev_scl_out,
		output dev_sda_oe, output dev_sda_out);
	modport host (input scl, input sda, output host_scl_oe, output host_scl_out,
		output host_sda_oe, output host_sda_out);
endinterface

// [rtl/i2cbl_host.sv]
`timescale 1ns/1ps
module i2cbl_host (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Bus.
	i2cbl_if.host bus,
	// Command.
	input wire logic cmd_valid_i,
	input wire logic cmd_read_i,
	input wire logic cmd_fast_i,
	input wire logic cmd_cs_i,
	input wire logic [7:0] cmd_sub_i,
	input wire logic [4:0] cmd_len_i,
	input wire logic [8*i2cbl_pkg::MAX_BYTES-1:0] cmd_data_i,
	output logic cmd_ready_o,
	// Answer.
	output logic rd_valid_o,
	output logic [7:0] rd_data_o,
	output logic nack_o,
	output logic done_o
);
	import i2cbl_pkg::*;
	typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} i2cbl_hst_t;
	i2cbl_hst_t hs_reg;
	logic [7:0] cnt_reg, bitc_reg, sh_reg;
	logic [3:0] bit_reg;
	logic [4:0] idx_reg, len_reg;
	logic [8*MAX_BYTES-1:0] d_reg;
	logic rd_reg, cs_reg, ph2_reg, rx_reg, scl_oe_reg, sda_oe_reg;
	logic [7:0] sub_reg;
	wire at_q = cnt_reg == (bitc_reg >> 2);
	wire at_h = cnt_reg == (bitc_reg >> 1);
	wire at_3q = cnt_reg == ((bitc_reg >> 1) + (bitc_reg >> 2));
	wire at_end = cnt_reg == bitc_reg - 8'h01;
	wire byte_end = (hs_reg == H_BYTE) && at_end && (bit_reg == 4'h8);
	wire not_last = idx_reg != len_reg;
	wire [4:0] idx_inc = idx_reg + 5'h01;
	wire [7:0] top_b = d_reg[8*MAX_BYTES-1 -: 8];

	assign cmd_ready_o = hs_reg == H_IDLE;
	assign bus.host_scl_out = 1'b0;
	assign bus.host_sda_out = 1'b0;
	assign bus.host_scl_oe = scl_oe_reg;
	assign bus.host_sda_oe = sda_oe_reg;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hs_reg <= H_IDLE;
			{cnt_reg, bitc_reg, sh_reg, sub_reg} <= 32'h0000_0000;
			{bit_reg, idx_reg, len_reg} <= 14'h0000;
			d_reg <= '0;
			{rd_reg, cs_reg, ph2_reg, rx_reg, scl_oe_reg, sda_oe_reg} <= 6'h00;
			{rd_valid_o, rd_data_o, nack_o, done_o} <= 11'h000;
		end else begin
			rd_valid_o <= 1'b0;
			done_o <= 1'b0;
			cnt_reg <= (hs_reg == H_IDLE || at_end) ? 8'h00 : cnt_reg + 8'h01;
			case (hs_reg)
				H_IDLE: if (cmd_valid_i) begin
					hs_reg <= H_START;
					bitc_reg <= cmd_fast_i ? HST_FAST_BIT : HST_STD_BIT;
					{rd_reg, cs_reg, sub_reg, len_reg} <= {cmd_read_i, cmd_cs_i, cmd_sub_i, cmd_len_i};
					d_reg <= cmd_data_i;
					{ph2_reg, nack_o, idx_reg} <= 7'h00;
				end
				H_START: begin
					if (cnt_reg == 8'h00) scl_oe_reg <= 1'b1;
					if (at_q) sda_oe_reg <= 1'b0;
					if (at_h) scl_oe_reg <= 1'b0;
					if (at_3q) sda_oe_reg <= 1'b1;
					if (at_end) begin
						hs_reg <= H_BYTE;
						{bit_reg, rx_reg} <= 5'h00;
						sh_reg <= {SLV_BASE, cs_reg, ph2_reg};
					end
				end
				H_BYTE: begin
					if (cnt_reg == 8'h00) scl_oe_reg <= 1'b1;
					if (at_q) sda_oe_reg <= (bit_reg != 4'h8) ? (~rx_reg & ~sh_reg[7]) : (rx_reg & not_last);
					if (at_h) scl_oe_reg <= 1'b0;
					if (at_end && bit_reg != 4'h8) begin
						sh_reg <= {sh_reg[6:0], bus.sda};
						bit_reg <= bit_reg + 4'h1;
					end
					if (byte_end) begin
						bit_reg <= 4'h0;
						idx_reg <= idx_inc;
						if (rx_reg) begin
							{rd_valid_o, rd_data_o} <= {1'b1, sh_reg};
							if (!not_last) hs_reg <= H_STOP;
						end else if (bus.sda) begin
							nack_o <= 1'b1;
							hs_reg <= H_STOP;
						end else if (ph2_reg) begin
							rx_reg <= 1'b1;
						end else if (idx_reg == 5'h00) begin
							sh_reg <= sub_reg;
						end else if (rd_reg || idx_reg == len_reg + 5'h01) begin
							hs_reg <= H_STOP;
						end else begin
							sh_reg <= top_b;
							d_reg <= d_reg << 8;
						end
					end
				end
				default: begin
					if (cnt_reg == 8'h00) scl_oe_reg <= 1'b1;
					if (at_q) sda_oe_reg <= 1'b1;
					if (at_h) scl_oe_reg <= 1'b0;
					if (at_3q) sda_oe_reg <= 1'b0;
					if (at_end) begin
						if (rd_reg && !ph2_reg && !nack_o) begin
							hs_reg <= H_START;
							ph2_reg <= 1'b1;
							idx_reg <= 5'h00;
						end else begin
							hs_reg <= H_IDLE;
							done_o <= 1'b1;
						end
					end
				end
			endcase
		end
	end
endmodule // i2cbl_host

// [rtl/i2cbl_dev.sv]
`timescale 1ns/1ps
// What this block does
// - Slave follows standard and fast rates, 20-byte bursts.
// - Boot master clocks bus near 375 kHz.
// - Reset starts master on, slave off.
// - Boot probes memory at address 101000x.
// - Load segments, zero length ends, then slave.
// - No answer or error: default config, slave.
// - Default config passes audio while GPIO low.
// - Master and slave never drive together.
// - Loaded program memory locked until reset.
// - Host sets subaddress, then reads separately.
// - First written byte is always new subaddress.
// - Slave address is base, select bit, R/W.
// - Select pin sampled once after reset.
// - Slave also answers general call.
// - Memory address is base, select bit, R/W.
// - Reads stream bytes while host acknowledges.
// - Unused bits of a subaddress read zero.
// - Incomplete word set at stop/start is dropped.
// - External master alone sets slave clock rate.
// - Sequential write keeps complete sets, drops partial.
// - Boot retries three attempts, checksum three passes.
module i2cbl_dev (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Bus.
	i2cbl_if.dev bus,
	// Straps and pins.
	input wire logic addr_select_pin_i,
	input wire logic gpio_i,
	// Boot memory load port.
	output logic mem_we_o,
	output logic [2:0] mem_tgt_o,
	output logic [15:0] mem_addr_o,
	output logic [7:0] mem_data_o,
	// Slave configuration write port.
	output logic cfg_we_o,
	output logic [7:0] cfg_sub_o,
	output logic [2:0] cfg_words_o,
	output logic [8*i2cbl_pkg::MAX_BYTES-1:0] cfg_data_o,
	// Slave read port.
	output logic [7:0] rd_sub_o,
	input wire logic [31:0] rd_word_i,
	// Status.
	output logic slave_mode_o,
	output logic default_cfg_o,
	output logic passthru_o,
	output logic prog_lock_o
);
	import i2cbl_pkg::*;
	typedef enum logic [2:0] {MS_WAIT, MS_START, MS_BYTE, MS_STOP, MS_END} i2cbl_mst_t;
	typedef enum logic [2:0] {P_TGT, P_LH, P_LL, P_DAT, P_C0, P_C1} i2cbl_parse_t;
	typedef enum logic [2:0] {SS_IDLE, SS_ADDR, SS_AACK, SS_WR, SS_WACK, SS_RD, SS_RACK} i2cbl_slv_t;

	i2cbl_mode_t mode_reg;
	logic cs_reg, cs_cap_reg, default_reg, prog_lock_reg;
	i2cbl_mst_t ms_reg;
	i2cbl_parse_t p_reg, p_next;
	logic [6:0] m_cnt_reg;
	logic [3:0] m_bit_reg;
	logic [7:0] m_sh_reg, ck_hi_reg;
	logic [2:0] m_step_reg, tgt_reg;
	logic m_rx_reg, m_last_reg, m_scl_oe_reg, m_sda_oe_reg, m_ok_reg, m_cks_bad_reg;
	logic [1:0] m_try_reg, m_ck_try_reg;
	logic [15:0] len_reg, addr_reg, sum_reg;
	logic prog_seen_reg;

	// Strap capture on the first clock after reset release.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{cs_reg, cs_cap_reg} <= 2'h0;
		end else if (!cs_cap_reg) begin
			cs_reg <= addr_select_pin_i;
			cs_cap_reg <= 1'b1;
		end
	end

	wire boot = mode_reg == MODE_BOOT;
	wire m_end = m_cnt_reg == MST_BIT_CYC - 7'h01;
	wire m_q = m_cnt_reg == (MST_BIT_CYC >> 2);
	wire m_h = m_cnt_reg == (MST_BIT_CYC >> 1);
	wire m_3q = m_cnt_reg == ((MST_BIT_CYC >> 1) + (MST_BIT_CYC >> 2));
	wire bus_idle = bus.scl & bus.sda;
	wire m_byte_end = (ms_reg == MS_BYTE) && m_end && (m_bit_reg == 4'h8);
	wire m_rx_done = m_byte_end && m_rx_reg;
	wire hdr_bad = (p_reg == P_TGT) && (m_sh_reg > {5'h00, TGT_MAX});
	wire [15:0] new_len = {len_reg[15:8], m_sh_reg};
	wire cks_ok = {ck_hi_reg, m_sh_reg} == sum_reg;
	wire retry_rd = !m_cks_bad_reg && (m_try_reg != RETRY_LAST);
	wire retry_ck = m_cks_bad_reg && (m_ck_try_reg != CKSUM_LAST);
	wire boot_fin = boot && (ms_reg == MS_END);
	wire lock_set;

	always_comb begin
		case (p_reg)
			P_TGT: p_next = P_LH;
			P_LH: p_next = P_LL;
			P_LL: p_next = (new_len == 16'h0000) ? P_C0 : P_DAT;
			P_DAT: p_next = (len_reg == 16'h0001) ? P_TGT : P_DAT;
			P_C0: p_next = P_C1;
			default: p_next = P_C1;
		endcase
	end

	// Boot master: one bus bit per MST_BIT_CYC cycles.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ms_reg <= MS_WAIT;
			mode_reg <= MODE_BOOT;
			{default_reg, m_rx_reg, m_last_reg, m_scl_oe_reg, m_sda_oe_reg} <= 5'h00;
			{m_ok_reg, m_cks_bad_reg, m_try_reg, m_ck_try_reg} <= 6'h00;
			{m_cnt_reg, m_bit_reg, m_sh_reg, m_step_reg} <= 22'h00_0000;
		end else begin
			m_cnt_reg <= (m_end || (ms_reg == MS_WAIT && !bus_idle)) ? 7'h00 : m_cnt_reg + 7'h01;
			case (ms_reg)
				MS_WAIT: begin
					{m_scl_oe_reg, m_sda_oe_reg, m_step_reg} <= 5'h00;
					if (m_end && cs_cap_reg) ms_reg <= MS_START;
				end
				MS_START: begin
					if (m_cnt_reg == 7'h00) m_scl_oe_reg <= 1'b1;
					if (m_q) m_sda_oe_reg <= 1'b0;
					if (m_h) m_scl_oe_reg <= 1'b0;
					if (m_3q) m_sda_oe_reg <= 1'b1;
					if (m_end) begin
						ms_reg <= MS_BYTE;
						{m_bit_reg, m_rx_reg} <= 5'h00;
						m_sh_reg <= {MST_BASE, cs_reg, m_step_reg != 3'h0};
					end
				end
				MS_BYTE: begin
					if (m_cnt_reg == 7'h00) m_scl_oe_reg <= 1'b1;
					if (m_q) m_sda_oe_reg <= (m_bit_reg != 4'h8) ? (~m_rx_reg & ~m_sh_reg[7]) :
						(m_rx_reg & ~m_last_reg);
					if (m_h) m_scl_oe_reg <= 1'b0;
					if (m_end && m_bit_reg != 4'h8) begin
						m_sh_reg <= {m_sh_reg[6:0], bus.sda};
						m_bit_reg <= m_bit_reg + 4'h1;
					end
					if (m_byte_end) begin
						m_bit_reg <= 4'h0;
						if (m_rx_reg) begin
							m_last_reg <= p_next == P_C1;
							if (hdr_bad) ms_reg <= MS_STOP;
							if (p_reg == P_C1) begin
								ms_reg <= MS_STOP;
								m_ok_reg <= cks_ok;
								m_cks_bad_reg <= !cks_ok;
							end
						end else if (bus.sda) begin
							ms_reg <= MS_STOP;
						end else begin
							m_step_reg <= m_step_reg + 3'h1;
							m_sh_reg <= (m_step_reg == 3'h0) ? EE_SUB_HI : EE_SUB_LO;
							if (m_step_reg == 3'h2) ms_reg <= MS_START;
							if (m_step_reg == 3'h3) {m_rx_reg, m_last_reg} <= 2'h2;
						end
					end
				end
				MS_STOP: begin
					if (m_cnt_reg == 7'h00) m_scl_oe_reg <= 1'b1;
					if (m_q) m_sda_oe_reg <= 1'b1;
					if (m_h) m_scl_oe_reg <= 1'b0;
					if (m_3q) m_sda_oe_reg <= 1'b0;
					if (m_end) ms_reg <= MS_END;
				end
				default: if (boot) begin
					if (m_ok_reg) begin
						mode_reg <= MODE_SLAVE;
					end else if (retry_ck || retry_rd) begin
						ms_reg <= MS_WAIT;
						m_ck_try_reg <= m_ck_try_reg + {1'b0, retry_ck};
						m_try_reg <= m_try_reg + {1'b0, retry_rd};
						m_cks_bad_reg <= 1'b0;
					end else begin
						default_reg <= 1'b1;
						mode_reg <= MODE_SLAVE;
					end
				end
			endcase
		end
	end

	// Memory image parser and load port.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			p_reg <= P_TGT;
			{tgt_reg, len_reg, addr_reg, sum_reg, ck_hi_reg, prog_seen_reg} <= 60'h0;
			{mem_we_o, mem_tgt_o, mem_addr_o, mem_data_o} <= 28'h000_0000;
		end else begin
			mem_we_o <= m_rx_done && (p_reg == P_DAT) && !(tgt_reg == TGT_PROG && prog_lock_reg);
			if (ms_reg == MS_WAIT) begin
				{p_reg, sum_reg, prog_seen_reg} <= {P_TGT, 16'h0000, 1'b0};
			end else if (m_rx_done) begin
				p_reg <= p_next;
				case (p_reg)
					P_TGT: tgt_reg <= m_sh_reg[2:0];
					P_LH: len_reg[15:8] <= m_sh_reg;
					P_LL: {len_reg[7:0], addr_reg} <= {m_sh_reg, 16'h0000};
					P_DAT: begin
						{mem_tgt_o, mem_addr_o, mem_data_o} <= {tgt_reg, addr_reg, m_sh_reg};
						addr_reg <= addr_reg + 16'h0001;
						len_reg <= len_reg - 16'h0001;
						sum_reg <= sum_reg + {8'h00, m_sh_reg};
						prog_seen_reg <= prog_seen_reg | (tgt_reg == TGT_PROG);
					end
					P_C0: ck_hi_reg <= m_sh_reg;
					default: ;
				endcase
			end
		end
	end

	// Slave port, sampling the bus on every clock.
	i2cbl_slv_t ss_reg;
	logic scl_q_reg, sda_q_reg, s_rw_reg, s_sda_oe_reg, s_first_reg, s_ack_reg, commit_reg;
	logic [3:0] s_bit_reg;
	logic [7:0] s_sh_reg, sub_reg, cfg_sub_reg;
	logic [4:0] wcnt_reg;
	logic [1:0] rbyte_reg;
	logic [7:0] buf_reg [0:MAX_BYTES-1];
	wire s_rise = bus.scl & ~scl_q_reg;
	wire s_fall = ~bus.scl & scl_q_reg;
	wire s_start = scl_q_reg & bus.scl & sda_q_reg & ~bus.sda;
	wire s_stop = scl_q_reg & bus.scl & ~sda_q_reg & bus.sda;
	wire s_match = (s_sh_reg[7:1] == {SLV_BASE, cs_reg}) || (s_sh_reg == GEN_CALL);
	wire [4:0] set_len = {sub_words(sub_reg), 2'h0};
	wire [7:0] status_w = {4'h0, m_cks_bad_reg, prog_lock_reg, default_reg, !boot};
	wire [31:0] rd_w = ((sub_reg == STATUS_SUB) ? {24'h00_0000, status_w} : rd_word_i) &
		sub_mask(sub_reg);
	wire [7:0] rd_b = rd_w[{~rbyte_reg, 3'h0} +: 8];
	wire wr_byte = (ss_reg == SS_WR) && s_fall && (s_bit_reg == 4'h8);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ss_reg <= SS_IDLE;
			{scl_q_reg, sda_q_reg} <= 2'h3;
			{s_rw_reg, s_sda_oe_reg, s_first_reg, s_ack_reg, s_bit_reg, s_sh_reg} <= 16'h0000;
		end else begin
			{scl_q_reg, sda_q_reg} <= {bus.scl, bus.sda};
			if (boot || s_start || s_stop) begin
				ss_reg <= (!boot && s_start) ? SS_ADDR : SS_IDLE;
				{s_bit_reg, s_sda_oe_reg} <= 5'h00;
			end else begin
				case (ss_reg)
					SS_ADDR, SS_WR: begin
						if (s_rise) {s_sh_reg, s_bit_reg} <= {s_sh_reg[6:0], bus.sda, s_bit_reg + 4'h1};
						if (s_fall && s_bit_reg == 4'h8) begin
							ss_reg <= (ss_reg == SS_WR) ? SS_WACK : (s_match ? SS_AACK : SS_IDLE);
							s_sda_oe_reg <= (ss_reg == SS_WR) || s_match;
							if (ss_reg == SS_ADDR) {s_rw_reg, s_first_reg} <= {s_sh_reg[0], 1'b1};
							if (ss_reg == SS_WR) s_first_reg <= 1'b0;
						end
					end
					SS_AACK, SS_WACK: if (s_fall) begin
						s_bit_reg <= 4'h0;
						ss_reg <= (ss_reg == SS_AACK && s_rw_reg) ? SS_RD : SS_WR;
						s_sh_reg <= rd_b;
						s_sda_oe_reg <= (ss_reg == SS_AACK && s_rw_reg) && !rd_b[7];
					end
					SS_RD: if (s_fall) begin
						ss_reg <= (s_bit_reg == 4'h7) ? SS_RACK : SS_RD;
						s_sda_oe_reg <= (s_bit_reg != 4'h7) && !s_sh_reg[6];
						s_sh_reg <= s_sh_reg << 1;
						s_bit_reg <= s_bit_reg + 4'h1;
					end
					SS_RACK: begin
						if (s_rise) s_ack_reg <= !bus.sda;
						if (s_fall) begin
							ss_reg <= s_ack_reg ? SS_RD : SS_IDLE;
							{s_sh_reg, s_bit_reg} <= {rd_b, 4'h0};
							s_sda_oe_reg <= s_ack_reg && !rd_b[7];
						end
					end
					default: ;
				endcase
			end
		end
	end

	// Subaddress, word assembly and read pointer.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{sub_reg, cfg_sub_reg, wcnt_reg, rbyte_reg, commit_reg} <= 24'h00_0000;
			for (int i = 0; i < MAX_BYTES; i++) buf_reg[i] <= 8'h00;
		end else begin
			commit_reg <= 1'b0;
			if (boot || s_start || s_stop) begin
				wcnt_reg <= 5'h00;
			end else if (wr_byte && s_first_reg) begin
				{sub_reg, wcnt_reg, rbyte_reg} <= {s_sh_reg, 7'h00};
			end else if (wr_byte) begin
				buf_reg[wcnt_reg] <= s_sh_reg;
				wcnt_reg <= (wcnt_reg == set_len - 5'h01) ? 5'h00 : wcnt_reg + 5'h01;
				if (wcnt_reg == set_len - 5'h01) begin
					{commit_reg, cfg_sub_reg} <= {1'b1, sub_reg};
					sub_reg <= sub_reg + 8'h01;
				end
			end else if (ss_reg == SS_RACK && s_rise && !bus.sda) begin
				rbyte_reg <= rbyte_reg + 2'h1;
				if (rbyte_reg == 2'h3) sub_reg <= sub_reg + 8'h01;
			end
		end
	end

	assign lock_set = cfg_we_o && (cfg_sub_reg == PROG_SUB);
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) prog_lock_reg <= 1'b0;
		else prog_lock_reg <= prog_lock_reg | lock_set | (boot_fin && m_ok_reg && prog_seen_reg);
	end

	genvar gi;
	generate
		for (gi = 0; gi < MAX_BYTES; gi++) begin : g_pack
			assign cfg_data_o[8*(MAX_BYTES-1-gi) +: 8] = buf_reg[gi];
		end
	endgenerate

	assign cfg_we_o = commit_reg && !(cfg_sub_reg == PROG_SUB && prog_lock_reg);
	assign cfg_sub_o = cfg_sub_reg;
	assign cfg_words_o = sub_words(cfg_sub_reg);
	assign rd_sub_o = sub_reg;
	assign bus.dev_scl_out = 1'b0;
	assign bus.dev_sda_out = 1'b0;
	assign bus.dev_scl_oe = boot && m_scl_oe_reg;
	assign bus.dev_sda_oe = boot ? m_sda_oe_reg : s_sda_oe_reg;
	assign slave_mode_o = !boot;
	assign default_cfg_o = default_reg;
	assign passthru_o = default_reg && !gpio_i;
	assign prog_lock_o = prog_lock_reg;
endmodule // i2cbl_dev

// [test/i2cbl_monitor.sv]
`timescale 1ns/1ps
module i2cbl_monitor (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Wire levels and enables.
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_scl_oe,
	input wire logic dev_sda_oe,
	input wire logic host_scl_oe,
	input wire logic host_sda_oe
);
	import i2cbl_pkg::*;
	logic [7:0] low_cnt;
	logic [7:0] idle_cnt;
	logic started;
	logic host_seen;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			low_cnt <= 8'h00;
			idle_cnt <= 8'h00;
			started <= 1'b0;
			host_seen <= 1'b0;
		end else begin
			low_cnt <= dev_scl_oe ? low_cnt + 8'h01 : 8'h00;
			idle_cnt <= !(scl && sda) ? 8'h00 : idle_cnt + 8'(idle_cnt != 8'hFF);
			started <= started | dev_scl_oe;
			host_seen <= host_seen | host_scl_oe | host_sda_oe;
		end
	end
	sequence s_dev_start;
		$rose(dev_sda_oe) && scl;
	endsequence
	sequence s_start_low;
		(scl && !sda) [*8] ##[1:10] !scl;
	endsequence
	a_scl_low_time: assert property ($fell(dev_scl_oe) |-> low_cnt == 8'h1A)
		else $error("boot clock low phase has the wrong length");
	a_data_setup: assert property ($rose(dev_scl_oe) |=> $stable(dev_sda_oe) [*8])
		else $error("boot data moved too soon after clock fall");
	a_first_start: assert property ($rose(dev_scl_oe) && !started |->
		idle_cnt >= 8'(MST_BIT_CYC) - 8'h01)
		else $error("boot master started before the bus was idle");
	a_start_shape: assert property (s_dev_start |-> s_start_low)
		else $error("boot start condition has the wrong shape");
	a_stop_release: assert property ($fell(dev_sda_oe) && scl |-> (scl && sda) [*8])
		else $error("bus not left idle after boot stop");
	a_reset_quiet: assert property ($rose(rst_n_i) |-> (!dev_scl_oe && !dev_sda_oe) [*8])
		else $error("bus driven right after reset");
	a_one_master: assert property (host_seen || host_scl_oe |-> !dev_scl_oe)
		else $error("boot master active beside the host");
	a_slave_sda_edge: assert property (host_seen && $changed(dev_sda_oe) |-> !scl)
		else $error("slave data changed while the clock was high");
endmodule // i2cbl_monitor

// [test/testbench.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
	$display("wrong value at %0t: %h vs %h", $time, a, b); end end
module testbench;
	import i2cbl_pkg::*;
	logic clk_i = 1'b0, rst_n_i = 1'b0, addr_select_pin_i = 1'b0, gpio_i = 1'b0;
	logic cmd_valid_i = 1'b0, cmd_read_i = 1'b0, cmd_fast_i = 1'b0, cmd_cs_i = 1'b0;
	logic [7:0] cmd_sub_i = 8'h00;
	logic [4:0] cmd_len_i = 5'h00;
	logic [159:0] cmd_data_i = '0;
	logic cmd_ready_o, rd_valid_o, nack_o, done_o, mem_we_o, cfg_we_o, scl_d;
	logic slave_mode_o, default_cfg_o, passthru_o, prog_lock_o;
	logic [7:0] rd_data_o, cfg_sub_o, rd_sub_o, mem_data_o, boot_sh;
	logic [2:0] mem_tgt_o, cfg_words_o;
	logic [15:0] mem_addr_o;
	logic [159:0] cfg_data_o;
	logic [31:0] rd_word_i;
	logic [7:0] rd_buf [0:19];
	int n_fail = 0, checks = 0, we_cnt = 0, nrd = 0, cyc = 0, bb = 0, mem_cnt = 0;
	i2cbl_if bus();
	assign bus.ext_scl_oe = 1'b0;
	assign bus.ext_sda_oe = 1'b0;
	assign rd_word_i = {4'hF, rd_sub_o[3:0], 24'hC3_A55A};
	i2cbl_dev i2cbl_dev_i (.clk_i, .rst_n_i, .bus(bus.dev), .addr_select_pin_i, .gpio_i,
		.mem_we_o, .mem_tgt_o, .mem_addr_o, .mem_data_o, .cfg_we_o, .cfg_sub_o,
		.cfg_words_o, .cfg_data_o, .rd_sub_o, .rd_word_i, .slave_mode_o, .default_cfg_o,
		.passthru_o, .prog_lock_o);
	i2cbl_host i2cbl_host_i (.clk_i, .rst_n_i, .bus(bus.host), .cmd_valid_i, .cmd_read_i,
		.cmd_fast_i, .cmd_cs_i, .cmd_sub_i, .cmd_len_i, .cmd_data_i, .cmd_ready_o,
		.rd_valid_o, .rd_data_o, .nack_o, .done_o);
	i2cbl_monitor i2cbl_monitor_i (.clk_i, .rst_n_i, .scl(bus.scl), .sda(bus.sda),
		.dev_scl_oe(bus.dev_scl_oe), .dev_sda_oe(bus.dev_sda_oe),
		.host_scl_oe(bus.host_scl_oe), .host_sda_oe(bus.host_sda_oe));
	always #25 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		if (cfg_we_o === 1'b1) we_cnt++;
		if (mem_we_o === 1'b1) mem_cnt++;
		if (rd_valid_o === 1'b1 && nrd < 20) begin
			rd_buf[nrd] = rd_data_o;
			nrd++;
		end
		if (rst_n_i === 1'b0) bb = 0;
		else if (slave_mode_o === 1'b0 && bus.scl === 1'b1 && scl_d === 1'b0) begin
			if (bb > 0 && bb < 9) boot_sh = {boot_sh[6:0], bus.sda};
			bb++;
		end
		scl_d = bus.scl;
		if (cyc == 90000) begin
			n_fail++;
			report_and_stop();
		end
	end
	function automatic logic [7:0] exp_byte(input logic [7:0] s, input int k);
		logic [31:0] w;
		w = {4'hF, s[3:0], 24'hC3_A55A};
		if (s >= 8'h10 && s <= 8'h1F) w[31:28] = 4'h0;
		return w[31-8*k -: 8];
	endfunction
	task automatic report_and_stop();
		if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic do_reset(input logic sel);
		int i;
		i = 0;
		rst_n_i = 1'b0;
		addr_select_pin_i = sel;
		repeat (3) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		`CHK(slave_mode_o, 1'b0)
		while (slave_mode_o !== 1'b1 && i < 8000) begin
			@(posedge clk_i) #1 i++;
		end
		repeat (20) @(posedge clk_i);
		#1 `CHK(default_cfg_o, 1'b1)
		`CHK(prog_lock_o, 1'b0)
		`CHK(boot_sh, {6'h28, sel, 1'b0})
		`CHK(mem_cnt, 0)
	endtask
	task automatic host_cmd(input logic rd, fast, cs, input logic [7:0] sub,
		input logic [4:0] len, input logic [31:0] w0, input int exp_we);
		int i;
		int we0;
		we0 = we_cnt;
		nrd = 0;
		i = 0;
		{cmd_read_i, cmd_fast_i, cmd_cs_i, cmd_sub_i, cmd_len_i} = {rd, fast, cs, sub, len};
		cmd_data_i = {5{w0}};
		while (cmd_ready_o !== 1'b1) @(posedge clk_i) #1;
		cmd_valid_i = 1'b1;
		@(posedge clk_i) #1 cmd_valid_i = 1'b0;
		while (done_o !== 1'b1 && i < 30000) begin
			@(posedge clk_i) #1 i++;
		end
		`CHK(we_cnt - we0, exp_we)
	endtask
	initial begin
		do_reset(1'b0);
		`CHK(passthru_o, 1'b1)
		gpio_i = 1'b1;
		#1 `CHK(passthru_o, 1'b0)
		host_cmd(1'b0, 1'b0, 1'b0, 8'h05, 5'd4, 32'h1122_3344, 1);
		`CHK(cfg_sub_o, 8'h05)
		`CHK(cfg_data_o[159:128], 32'h1122_3344)
		host_cmd(1'b0, 1'b1, 1'b0, 8'h10, 5'd8, 32'h0BAD_0BAD, 0);
		host_cmd(1'b0, 1'b1, 1'b0, 8'h10, 5'd20, 32'h0ABC_DEF0, 1);
		`CHK(cfg_words_o, 3'h5)
		`CHK(cfg_data_o[31:0], 32'h0ABC_DEF0)
		host_cmd(1'b0, 1'b1, 1'b0, 8'h06, 5'd10, 32'h5555_AAAA, 2);
		`CHK(cfg_sub_o, 8'h07)
		host_cmd(1'b0, 1'b1, 1'b0, 8'h20, 5'd4, 32'h1234_5678, 1);
		`CHK(prog_lock_o, 1'b1)
		host_cmd(1'b0, 1'b1, 1'b0, 8'h20, 5'd4, 32'h8765_4321, 0);
		host_cmd(1'b1, 1'b1, 1'b0, 8'h05, 5'd8, 32'h0000_0000, 0);
		`CHK(nrd, 8)
		for (int k = 0; k < 8; k++) `CHK(rd_buf[k], exp_byte(8'h05 + 8'(k / 4), k % 4))
		`CHK(rd_sub_o, 8'h06)
		host_cmd(1'b1, 1'b1, 1'b0, 8'h1E, 5'd4, 32'h0000_0000, 0);
		for (int k = 0; k < 4; k++) `CHK(rd_buf[k], exp_byte(8'h1E, k))
		host_cmd(1'b1, 1'b1, 1'b0, 8'h00, 5'd4, 32'h0000_0000, 0);
		`CHK({rd_buf[0], rd_buf[1], rd_buf[2], rd_buf[3]}, 32'h0000_0007)
		host_cmd(1'b0, 1'b1, 1'b1, 8'h05, 5'd4, 32'h0F0F_0F0F, 0);
		`CHK(nack_o, 1'b1)
		do_reset(1'b1);
		host_cmd(1'b0, 1'b1, 1'b1, 8'h20, 5'd4, 32'h0A0B_0C0D, 1);
		`CHK(nack_o, 1'b0)
		report_and_stop();
	end
endmodule // testbench
